/* File: bench/ltc_bus_model.sv */
`timescale 1ns/1ps
module ltc_bus_model (
  // Device driver side
  input wire logic lin_oe_n_i,
  // Remote node on the bus
  input wire logic remote_dom_i,
  // Resolved bus level
  output logic lin_o
);
  // Pull-up termination keeps a released bus recessive
  assign lin_o = ~(~lin_oe_n_i | remote_dom_i);
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, txd = 1, slp = 0, wk = 1, rem = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [3:0] sup = 4'h0;
  logic ack, irq, txo, txd_oe_n, rxd, rxd_oe_n, lin, lino, lin_oe_n, regulator_inhibit_out, inh_oe_n;
  int error_cnt = 0, check_count = 0;
  always #2.5 clk_i = ~clk_i;
  ltc_top #(.WAKE_LIN_CYC(20), .WAKE_LOC_CYC(10), .DOM_TIMEOUT_CYC(50)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .txd_i(txd), .txd_o(txo), .txd_oe_n_o(txd_oe_n), .sleep_control_n_i(slp),
    .wake_n_i(wk), .rxd_o(rxd), .rxd_oe_n_o(rxd_oe_n), .lin_i(lin), .lin_o(lino),
    .lin_oe_n_o(lin_oe_n), .regulator_inhibit_out_o(regulator_inhibit_out),
    .regulator_inhibit_oe_n_o(inh_oe_n), .supply_i(ltc_pkg::ltc_supply_s'(sup)));
  ltc_bus_model bus_u (.lin_oe_n_i(lin_oe_n), .remote_dom_i(rem), .lin_o(lin));

  function automatic logic [31:0] mw(input ltc_pkg::ltc_mode_e m);
    return {29'h0, m};
  endfunction
  function automatic logic bus_lvl(input logic t, input logic r);
    return t & ~r;
  endfunction

  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single cycle; only the watchdog ends a missing ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    we <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("register", e, q & m)
  endtask
  task automatic mode_is(input ltc_pkg::ltc_mode_e m);
    rd(ltc_pkg::REG_STATUS, 32'h7, mw(m));
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(3247));
    cy(2);
    rst_i <= 0;
    cy(1);
    `CHK("lin_oe_n", 1'b1, lin_oe_n)
    rd(ltc_pkg::REG_CTRL, 32'hffffffff, 32'h3);
    rd(ltc_pkg::REG_IRQ_MASK, 32'hffffffff, 32'h0);
    rd(8'h40, 32'hffffffff, 32'h0);
    sup[3] <= 1;
    cy(8);
    mode_is(ltc_pkg::MODE_POWER_ON);
    `CHK("rxd_oe_n", 1'b1, rxd_oe_n)
    `CHK("inh", 1'b1, regulator_inhibit_out)
    `CHK("inh_oe_n", 1'b0, inh_oe_n)
    wb(1'b1, ltc_pkg::REG_IRQ_MASK, 32'h1 << ltc_pkg::IRQ_TO);
    rd(ltc_pkg::REG_IRQ_MASK, 32'h1f, 32'h1 << ltc_pkg::IRQ_TO);
    slp <= 1;
    cy(900);
    mode_is(ltc_pkg::MODE_POWER_ON);
    cy(120);
    mode_is(ltc_pkg::MODE_NORMAL);
    for (int i = 0; i < 24; i++) begin
      // Recessive every fourth bit bounds each dominant stretch
      txd <= (i % 4 == 3) ? 1'b1 : 1'($urandom);
      rem <= ($urandom % 4 == 0);
      cy(8);
      `CHK("lin_oe_n", txd, lin_oe_n)
      `CHK("rxd", bus_lvl(txd, rem), rxd)
    end
    rem <= 0;
    txd <= 0;
    cy(40);
    `CHK("lin_oe_n", 1'b0, lin_oe_n)
    cy(30);
    `CHK("lin_oe_n", 1'b1, lin_oe_n)
    rd(ltc_pkg::REG_STATUS, 32'h1 << ltc_pkg::ST_TO, 32'h1 << ltc_pkg::ST_TO);
    `CHK("irq", 1'b1, irq)
    rd(ltc_pkg::REG_IRQ_STAT, 32'h1f, 32'h1 << ltc_pkg::IRQ_TO);
    cy(3);
    `CHK("irq", 1'b0, irq)
    txd <= 1;
    cy(8);
    txd <= 0;
    cy(8);
    `CHK("lin_oe_n", 1'b0, lin_oe_n)
    txd <= 1;
    cy(8);
    for (int k = 0; k < 2; k++) begin
      txd <= 0;
      sup[k] <= 1;
      cy(8);
      `CHK("lin_oe_n", 1'b1, lin_oe_n)
      `CHK("irq", 1'b0, irq)
      sup[k] <= 0;
      cy(8);
      `CHK("lin_oe_n", 1'b0, lin_oe_n)
      txd <= 1;
      cy(4);
    end
    // Over-temperature and undervoltage bits sit side by side
    rd(ltc_pkg::REG_IRQ_STAT, 32'h1f, 32'h3 << ltc_pkg::IRQ_OT);
    sup[2] <= 1;
    cy(8);
    mode_is(ltc_pkg::MODE_SLEEP);
    `CHK("inh_oe_n", 1'b1, inh_oe_n)
    sup[2] <= 0;
    slp <= 0;
    rem <= 1;
    cy(12);
    rem <= 0;
    cy(8);
    mode_is(ltc_pkg::MODE_SLEEP);
    rem <= 1;
    cy(40);
    rem <= 0;
    cy(4);
    mode_is(ltc_pkg::MODE_STANDBY);
    `CHK("rxd", 1'b0, rxd)
    `CHK("rxd_oe_n", 1'b0, rxd_oe_n)
    rd(ltc_pkg::REG_IRQ_STAT, 32'h1f, 32'h1 << ltc_pkg::IRQ_REMOTE);
    slp <= 1;
    cy(1010);
    mode_is(ltc_pkg::MODE_NORMAL);
    slp <= 0;
    cy(1010);
    mode_is(ltc_pkg::MODE_SLEEP);
    // Local wake disabled: a long pulse must not wake
    wb(1'b1, ltc_pkg::REG_CTRL, 32'h1 << ltc_pkg::CTRL_REMOTE_EN);
    rd(ltc_pkg::REG_CTRL, 32'hffffffff, 32'h1 << ltc_pkg::CTRL_REMOTE_EN);
    wk <= 0;
    cy(30);
    wk <= 1;
    mode_is(ltc_pkg::MODE_SLEEP);
    wb(1'b1, ltc_pkg::REG_CTRL, {30'h0, ltc_pkg::CTRL_RST});
    wk <= 0;
    cy(30);
    wk <= 1;
    cy(4);
    mode_is(ltc_pkg::MODE_STANDBY);
    `CHK("txd_oe_n", 1'b0, txd_oe_n)
    rd(ltc_pkg::REG_STATUS, 32'h1 << ltc_pkg::ST_LOCAL, 32'h1 << ltc_pkg::ST_LOCAL);
    rd(ltc_pkg::REG_IRQ_STAT, 32'h1f, 32'h1 << ltc_pkg::IRQ_LOCAL);
    `CHK("txd_o", 1'b0, txo)
    `CHK("lin_o", 1'b0, lino)
    sup[3] <= 0;
    cy(8);
    `CHK("rxd_oe_n", 1'b1, rxd_oe_n)
    `CHK("inh", 1'b0, regulator_inhibit_out)
    `CHK("inh_oe_n", 1'b1, inh_oe_n)
    print_verdict();
  end
endmodule

/* File: verilog/ltc_filter.sv */
`timescale 1ns/1ps
module ltc_filter #(
  parameter int unsigned CNT = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Condition and result
  input wire logic cond_i,
  output logic hit_o
);
  localparam int W = $clog2(CNT + 1);
  localparam logic [W-1:0] CNT_W = W'(CNT);

  logic [W-1:0] cnt_q;

  // Any break in the condition restarts the interval
  always_ff @(posedge clk_i) begin
    if (rst_i || !cond_i) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_W) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign hit_o = (cnt_q == CNT_W);
endmodule

/* File: verilog/ltc_pkg.sv */
package ltc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Filter and timeout times, typical figures
  localparam int unsigned WAKE_LIN_US = 80;
  localparam int unsigned WAKE_LOC_US = 30;
  localparam int unsigned GO_NORM_US = 5;
  localparam int unsigned GO_SLEEP_US = 5;
  localparam int unsigned DOM_TIMEOUT_MS = 55;
  localparam int unsigned WAKE_LIN_CYC = WAKE_LIN_US * CLK_MHZ;
  localparam int unsigned WAKE_LOC_CYC = WAKE_LOC_US * CLK_MHZ;
  localparam int unsigned GO_NORM_CYC = GO_NORM_US * CLK_MHZ;
  localparam int unsigned GO_SLEEP_CYC = GO_SLEEP_US * CLK_MHZ;
  localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000 * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;

  // Status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_OT = 3;
  localparam int ST_UV = 4;
  localparam int ST_TO = 5;
  localparam int ST_DRV = 6;
  localparam int ST_LOCAL = 7;

  // Interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_REMOTE = 0;
  localparam int IRQ_LOCAL = 1;
  localparam int IRQ_TO = 2;
  localparam int IRQ_OT = 3;
  localparam int IRQ_UV = 4;

  // Control fields
  localparam int CTRL_REMOTE_EN = 0;
  localparam int CTRL_LOCAL_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_NORMAL,
    MODE_POWER_ON
  } ltc_mode_e;

  // Analogue comparator indications
  typedef struct packed {
    logic vbat_present;
    logic por_low;
    logic undervolt;
    logic overtemp;
  } ltc_supply_s;
endpackage

/* File: verilog/ltc_top.sv */
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module ltc_top #(
  parameter int unsigned WAKE_LIN_CYC = ltc_pkg::WAKE_LIN_CYC,
  parameter int unsigned WAKE_LOC_CYC = ltc_pkg::WAKE_LOC_CYC,
  parameter int unsigned DOM_TIMEOUT_CYC = ltc_pkg::DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // Controller side pins
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_n_o,
  input wire logic sleep_control_n_i,
  input wire logic wake_n_i,
  output logic rxd_o,
  output logic rxd_oe_n_o,
  // Bus and regulator pins
  input wire logic lin_i,
  output logic lin_o,
  output logic lin_oe_n_o,
  output logic regulator_inhibit_out_o,
  output logic regulator_inhibit_oe_n_o,
  // Comparator indications
  input wire ltc_pkg::ltc_supply_s supply_i
);
  // Two-stage synchronisers for every asynchronous input
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {txd_i, sleep_control_n_i, wake_n_i, lin_i, supply_i};
      sync2_q <= sync1_q;
    end
  end

  // Reset to low, like the pad pull-downs on transmit and sleep-control
  logic txd_s;
  logic slp_s;
  logic wake_n_s;
  logic lin_s;
  ltc_pkg::ltc_supply_s sup_s;
  assign txd_s = sync2_q[7];
  assign slp_s = sync2_q[6];
  assign wake_n_s = sync2_q[5];
  assign lin_s = sync2_q[4];
  assign sup_s = sync2_q[3:0];

  ltc_pkg::ltc_mode_e mode_q;
  logic [1:0] ctrl_q;
  logic to_fault_q;
  logic local_src_q;
  logic txd_prev_q;
  logic ot_prev_q;
  logic uv_prev_q;

  logic lin_wake_hit;
  logic loc_wake_hit;
  logic norm_hit;
  logic sleep_hit;
  logic to_hit;
  logic in_sleep;
  logic in_normal;
  logic drv_en;

  assign in_sleep = (mode_q == ltc_pkg::MODE_SLEEP);
  assign in_normal = (mode_q == ltc_pkg::MODE_NORMAL);

  ltc_filter #(.CNT(WAKE_LIN_CYC)) u_lin_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(in_sleep && !lin_s && ctrl_q[ltc_pkg::CTRL_REMOTE_EN]),
    .hit_o(lin_wake_hit)
  );

  ltc_filter #(.CNT(WAKE_LOC_CYC)) u_loc_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(in_sleep && !wake_n_s && ctrl_q[ltc_pkg::CTRL_LOCAL_EN]),
    .hit_o(loc_wake_hit)
  );

  ltc_filter #(.CNT(ltc_pkg::GO_NORM_CYC)) u_go_norm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(slp_s && !in_normal && mode_q != ltc_pkg::MODE_OFF),
    .hit_o(norm_hit)
  );

  ltc_filter #(.CNT(ltc_pkg::GO_SLEEP_CYC)) u_go_sleep (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(!slp_s && in_normal),
    .hit_o(sleep_hit)
  );

  // Counts while transmit is dominant in normal mode and no timeout fault is held, even when over-temperature or undervoltage holds the driver off
  ltc_filter #(.CNT(DOM_TIMEOUT_CYC)) u_dom_to (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(in_normal && !txd_s && !to_fault_q),
    .hit_o(to_hit)
  );

  // Mode machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= ltc_pkg::MODE_OFF;
    end else if (!sup_s.vbat_present) begin
      mode_q <= ltc_pkg::MODE_OFF;
    end else begin
      unique case (mode_q)
        ltc_pkg::MODE_OFF: begin
          mode_q <= ltc_pkg::MODE_POWER_ON;
        end
        ltc_pkg::MODE_NORMAL: begin
          if (sup_s.por_low || sleep_hit) begin
            mode_q <= ltc_pkg::MODE_SLEEP;
          end
        end
        ltc_pkg::MODE_SLEEP: begin
          if (norm_hit) begin
            mode_q <= ltc_pkg::MODE_NORMAL;
          end else if (!slp_s && (lin_wake_hit || loc_wake_hit)) begin
            mode_q <= ltc_pkg::MODE_STANDBY;
          end
        end
        ltc_pkg::MODE_STANDBY, ltc_pkg::MODE_POWER_ON: begin
          if (norm_hit) begin
            mode_q <= ltc_pkg::MODE_NORMAL;
          end
        end
        // Unused codes fall back to the powered-down state
        default: begin
          mode_q <= ltc_pkg::MODE_OFF;
        end
      endcase
    end
  end

  // Wake source flag; sleep-control high drops it at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_src_q <= 1'b0;
    end else if (in_sleep && !slp_s && (lin_wake_hit || loc_wake_hit)) begin
      local_src_q <= loc_wake_hit;
    end else if (slp_s || mode_q != ltc_pkg::MODE_STANDBY) begin
      local_src_q <= 1'b0;
    end
  end

  // Dominant timeout fault, set wins over the clearing edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_fault_q <= 1'b0;
      txd_prev_q <= 1'b0;
    end else begin
      txd_prev_q <= txd_s;
      if (to_hit) begin
        to_fault_q <= 1'b1;
      end else if (txd_s && !txd_prev_q) begin
        to_fault_q <= 1'b0;
      end
    end
  end

  // Floating inputs read low, so sleep-control low keeps the driver off
  assign drv_en = !sup_s.overtemp && !sup_s.undervolt && !to_fault_q && in_normal;

  // Pin outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lin_oe_n_o <= 1'b1;
      rxd_o <= 1'b1;
      rxd_oe_n_o <= 1'b1;
      txd_oe_n_o <= 1'b1;
      regulator_inhibit_out_o <= 1'b0;
      regulator_inhibit_oe_n_o <= 1'b1;
    end else begin
      lin_oe_n_o <= !(drv_en && !txd_s);
      rxd_o <= in_normal ? lin_s : 1'b0;
      rxd_oe_n_o <= !(sup_s.vbat_present && (in_normal ||
                    (mode_q == ltc_pkg::MODE_STANDBY && !slp_s)));
      txd_oe_n_o <= !(mode_q == ltc_pkg::MODE_STANDBY && local_src_q && !slp_s);
      regulator_inhibit_out_o <= sup_s.vbat_present;
      regulator_inhibit_oe_n_o <= !(sup_s.vbat_present && !in_sleep &&
                                  mode_q != ltc_pkg::MODE_OFF);
    end
  end

  // Open-drain pins only ever pull low
  assign lin_o = 1'b0;
  assign txd_o = 1'b0;

  // Events
  logic [ltc_pkg::IRQ_W-1:0] ev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ot_prev_q <= 1'b0;
      uv_prev_q <= 1'b0;
    end else begin
      ot_prev_q <= sup_s.overtemp;
      uv_prev_q <= sup_s.undervolt;
    end
  end
  assign ev[ltc_pkg::IRQ_REMOTE] = in_sleep && !slp_s && lin_wake_hit && !loc_wake_hit;
  assign ev[ltc_pkg::IRQ_LOCAL] = in_sleep && !slp_s && loc_wake_hit;
  assign ev[ltc_pkg::IRQ_TO] = to_hit;
  assign ev[ltc_pkg::IRQ_OT] = sup_s.overtemp && !ot_prev_q;
  assign ev[ltc_pkg::IRQ_UV] = sup_s.undervolt && !uv_prev_q;

  // Wishbone slave, one wait state
  logic ack_q;
  logic req;
  logic take;
  logic [ltc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [ltc_pkg::IRQ_W-1:0] irq_mask_q;
  logic [31:0] status_w;
  assign req = wb_cyc_i && wb_stb_i;
  assign take = req && ack_q;
  assign status_w = {24'h000000, local_src_q, drv_en, to_fault_q,
                     sup_s.undervolt, sup_s.overtemp, mode_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q <= req && !ack_q;
      wb_dat_o <= 32'h00000000;
      if (req && !ack_q && !wb_we_i) begin
        unique case (wb_adr_i)
          ltc_pkg::REG_STATUS: wb_dat_o <= status_w;
          ltc_pkg::REG_IRQ_STAT: wb_dat_o <= {27'h0000000, irq_stat_q};
          ltc_pkg::REG_IRQ_MASK: wb_dat_o <= {27'h0000000, irq_mask_q};
          ltc_pkg::REG_CTRL: wb_dat_o <= {30'h00000000, ctrl_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= ltc_pkg::MASK_RST;
      ctrl_q <= ltc_pkg::CTRL_RST;
    end else if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ltc_pkg::REG_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[ltc_pkg::IRQ_W-1:0];
      end
      if (wb_adr_i == ltc_pkg::REG_CTRL) begin
        ctrl_q <= wb_dat_i[1:0];
      end
    end
  end

  // Read clears only the bits returned, so an event after the capture survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (take && !wb_we_i && wb_adr_i == ltc_pkg::REG_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~wb_dat_o[ltc_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  driver_off_ot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sup_s.overtemp |=> lin_oe_n_o) else $error("driver on during over-temperature");
  driver_off_uv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sup_s.undervolt |=> lin_oe_n_o) else $error("driver on during undervoltage");
  timeout_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    to_hit |=> to_fault_q ##1 lin_oe_n_o) else $error("driver on after timeout");
  timeout_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (to_fault_q && !to_hit && txd_s && !txd_prev_q) |=> !to_fault_q)
    else $error("timeout fault not cleared by rising edge");
  sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_normal && sleep_hit && sup_s.vbat_present) |=> mode_q == ltc_pkg::MODE_SLEEP)
    else $error("no sleep after held low sleep-control");
  por_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_normal && sup_s.por_low && sup_s.vbat_present) |=> in_sleep)
    else $error("no sleep on low supply");
  power_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_q == ltc_pkg::MODE_OFF && sup_s.vbat_present) |=>
    mode_q == ltc_pkg::MODE_POWER_ON) else $error("power-on mode not entered");
  wake_standby_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && lin_wake_hit && !slp_s && sup_s.vbat_present) |=>
    mode_q == ltc_pkg::MODE_STANDBY ##1 !rxd_o) else $error("wake did not reach standby");
  rxd_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !sup_s.vbat_present |=> rxd_oe_n_o) else $error("receive driven without supply");
  rxd_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_normal |=> rxd_o == $past(lin_s)) else $error("receive does not follow bus");
  norm_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (norm_hit && !in_normal && sup_s.vbat_present) |=> in_normal)
    else $error("normal mode not entered");

  // Mode and pin checks beyond the protection paths
  drive_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (drv_en && !txd_s) |=> !lin_oe_n_o) else $error("bus not driven dominant");
  drv_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !in_normal |=> lin_oe_n_o) else $error("driver on outside normal mode");
  wake_filter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && !lin_wake_hit && !loc_wake_hit && !norm_hit) |=>
    (in_sleep || mode_q == ltc_pkg::MODE_OFF)) else $error("sleep left without a filter hit");
  local_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && loc_wake_hit && !norm_hit && !slp_s && sup_s.vbat_present) |=>
    (mode_q == ltc_pkg::MODE_STANDBY && local_src_q)) else $error("local wake not flagged");
  stay_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_normal && !sleep_hit && !sup_s.por_low) |=>
    (in_normal || mode_q == ltc_pkg::MODE_OFF)) else $error("normal mode left early");
  txd_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_q != ltc_pkg::MODE_STANDBY) |=> txd_oe_n_o)
    else $error("wake source shown outside standby");
  fault_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (to_fault_q && !(txd_s && !txd_prev_q)) |=> to_fault_q)
    else $error("timeout fault dropped without rising edge");
  power_on_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_q == ltc_pkg::MODE_POWER_ON) |=> (rxd_oe_n_o && lin_oe_n_o))
    else $error("power-on mode drives a pin");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_stat_q[ltc_pkg::IRQ_TO] && irq_mask_q[ltc_pkg::IRQ_TO]) |=> irq_o)
    else $error("unmasked timeout event not signalled");
endmodule
